// [hw/power_mode_clock_control.sv]
// Power mode, cycle divider and clock source control
`timescale 1ns/10ps
module power_mode_clock_control #(
   parameter int WARMUP = pmm_pkg::WARMUP_CLKS
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire pmm_pkg::regReq_t  req,
   output logic [7:0]             rdata,
   input  wire pmm_pkg::coreStat_t coreStat,
   input  wire pmm_pkg::wakeEv_t  wakeEv,
   input  wire logic              xtalOscOk,
   output logic                   cpuFromRing,
   output logic                   crystalAmpOn,
   output logic                   coreClkEn,
   output logic                   periphClkEn,
   output logic                   bandgapOn,
   output logic                   cycleStrobe,
   output logic [1:0]             activeDiv
);
   import pmm_pkg::*;

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic       srcSelQ;
   logic       ringActQ;
   logic       refKeepQ;
   logic       ringWakeQ;
   divCode_t   divQ;
   divCode_t   divPendQ;
   logic       autoRstQ;
   logic       ampOffQ;
   logic       xtReadyQ;
   pwrState_t  stateQ;
   pwrState_t  stateD;
   logic [10:0] cycCntQ;
   logic       pendQ;
   // Filtered inputs, decodes and counter results
   coreStat_t  statS;
   wakeEv_t    evS;
   logic       oscOkS;
   logic       warmDone;
   logic       ringDone;
   logic       wrPc;
   logic       wrEx;
   logic       wrPm;
   logic       restore;
   logic       lastCyc;
   divCode_t   newDiv;

   // Decode a write to one address
   function automatic logic hit(input regReq_t r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   // Cycles per instruction cycle for a divider code
   function automatic logic [10:0] cycLen(input divCode_t d);
      case (d)
         DIV_64:   cycLen = CYC_64;
         DIV_1024: cycLen = CYC_1024;
         default:  cycLen = CYC_4;
      endcase
   endfunction

   // Write decodes; the divider field is looked at only on a write
   assign wrPc = hit(req, ADDR_POWER_CONTROL);
   assign wrEx = hit(req, ADDR_EXT_FLAGS);
   assign wrPm = hit(req, ADDR_POWER_MANAGE);
   assign newDiv = divCode_t'(req.wdata[PM_DIV_HI:PM_DIV_LO]);

   // ------------------------------------------------------------
   // Synchronisers for outside status and wake sources
   // ------------------------------------------------------------
   // Status levels from the core and serial ports
   pmm_sync #(.W($bits(coreStat_t))) uStat (
      .clk    (clk),
      .arst_n (arst_n),
      .din    (coreStat),
      .dout   (statS)
   );

   // Wake events and crystal status share one filter chain
   // Events must stand two cycles to get through it
   pmm_sync #(.W($bits(wakeEv_t) + 1)) uWake (
      .clk    (clk),
      .arst_n (arst_n),
      .din    ({wakeEv, xtalOscOk}),
      .dout   ({evS, oscOkS})
   );

   pmm_count #(.LIMIT(WARMUP)) uWarm (
      .clk    (clk),
      .arst_n (arst_n),
      .run    (!ampOffQ && oscOkS && stateQ != PS_STOP),
      .done   (warmDone)
   );

   // Crystal clocks are counted on clk, which stands in for them
   // ring period before crystal hand-back
   pmm_count #(.LIMIT(WARMUP)) uRing (
      .clk    (clk),
      .arst_n (arst_n),
      .run    (stateQ == PS_RING && oscOkS),
      .done   (ringDone)
   );

   // ------------------------------------------------------------
   // Power state machine
   // ------------------------------------------------------------
   // Next power state from power writes and wake events
   // Stop wins over idle when a write sets both bits
   always_comb begin
      stateD = stateQ;
      case (stateQ)
         PS_RUN: begin
            if (wrPc && req.wdata[PC_STOP_BIT]) begin
               stateD = PS_STOP;
            end else if (wrPc && req.wdata[PC_IDLE_BIT]) begin
               stateD = PS_IDLE;
            end
         end
         PS_IDLE: begin
            if (evS.anyIrq) begin
               stateD = PS_RUN;
            end
         end
         PS_STOP: begin
            if (evS.extIrq || evS.rtcIrq ||
                (refKeepQ && (evS.supplyWarn || evS.pfReset))) begin
               stateD = ringWakeQ ? PS_RING : PS_RUN;
            end
         end
         PS_RING: begin
            if (ringDone) begin
               stateD = PS_RUN;
            // Stop may cut the ring period short
            end else if (wrPc && req.wdata[PC_STOP_BIT]) begin
               stateD = PS_STOP;
            end
         end
         default: stateD = PS_RUN;
      endcase
   end

   // Power state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stateQ <= PS_RUN;
      end else begin
         stateQ <= stateD;
      end
   end

   // ------------------------------------------------------------
   // Clock source select and amp disable
   // ------------------------------------------------------------
   // Source select; a refused write leaves it as it was
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         srcSelQ <= RST_SRCSEL;
      end else if (wrEx) begin
         // guarded 0 to 1; otherwise takes the written bit
         if (req.wdata[EX_SRCSEL_BIT] && !srcSelQ) begin
            if (xtReadyQ && !ampOffQ) begin
               srcSelQ <= 1'b1;
            end
         end else begin
            srcSelQ <= req.wdata[EX_SRCSEL_BIT];
         end
      end
   end

   // Amp disable; accepted only while the ring runs the CPU
   // so the crystal cannot be cut under a running core
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ampOffQ <= 1'b0;
      end else if (wrPm) begin
         // set only with ring selected; reject
         if (!req.wdata[PM_AMPOFF_BIT] || !srcSelQ) begin
            ampOffQ <= req.wdata[PM_AMPOFF_BIT];
         end
      end
   end

   // Ready drops with the amp off or in stop; warm-up restarts
   // crystal ready follows warm-up
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         xtReadyQ <= RST_XTREADY;
      end else if (ampOffQ || stateQ == PS_STOP) begin
         xtReadyQ <= 1'b0;
      end else if (warmDone) begin
         xtReadyQ <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ringActQ <= 1'b0;
      end else begin
         ringActQ <= (stateD == PS_RING) || !srcSelQ;
      end
   end

   // ------------------------------------------------------------
   // Band-gap keep, ring wake and auto restore enable
   // ------------------------------------------------------------
   // Stop options, freely writable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         refKeepQ  <= 1'b0;
         ringWakeQ <= 1'b0;
      end else if (wrEx) begin
         refKeepQ  <= req.wdata[EX_REFKEEP_BIT];
         ringWakeQ <= req.wdata[EX_RINGWAKE_BIT];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         autoRstQ <= 1'b0;
      end else if (wrPm) begin
         autoRstQ <= req.wdata[PM_AUTORST_BIT];
      end
   end

   // ------------------------------------------------------------
   // Cycle divider
   // ------------------------------------------------------------
   // Restore needs the enable; the clock source is never touched
   // restore events, divider only
   assign restore = autoRstQ &&
                    (evS.extIrq || evS.startBit || evS.txWrite);

   // Requested divider; a restore wins over a same-cycle write
   // Reserved code 00 is refused like an illegal slow code
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         divQ <= DIV_4;
      end else if (restore) begin
         divQ <= DIV_4;
      end else if (wrPm) begin
         // slow codes only from 4 clocks
         if (newDiv == DIV_4) begin
            divQ <= DIV_4;
         end else if (newDiv != DIV_RSVD && divQ == DIV_4) begin
            divQ <= newDiv;
         end
      end
   end

   // Last clock of the instruction cycle now in force
   assign lastCyc = (cycCntQ == 11'(cycLen(divPendQ) - 11'h001));

   // A change waits for the running cycle to end, so no cycle
   // is cut short or stretched by a mix of two rates
   // new rate applied at first cycle boundary after pendQ is set
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         divPendQ <= DIV_4;
         pendQ    <= 1'b0;
      end else if (divQ != activeDiv && !pendQ) begin
         pendQ <= 1'b1;
      end else if (pendQ && lastCyc) begin
         divPendQ <= divQ;
         pendQ    <= 1'b0;
      end
   end

   // Cycle counter, strobe and the divider code in force
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cycCntQ     <= '0;
         cycleStrobe <= 1'b0;
         activeDiv   <= DIV_4;
      end else begin
         cycleStrobe <= lastCyc;
         activeDiv   <= divPendQ;
         cycCntQ     <= lastCyc ? '0 : cycCntQ + 11'h001;
      end
   end

   // ------------------------------------------------------------
   // Clock and analog enables
   // ------------------------------------------------------------
   // Enables follow the next state so they move with the state
   // register and never lag it by a cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cpuFromRing  <= 1'b0;
         crystalAmpOn <= 1'b1;
         coreClkEn    <= 1'b1;
         periphClkEn  <= 1'b1;
         bandgapOn    <= 1'b1;
      end else begin
         cpuFromRing  <= !srcSelQ || stateD == PS_RING;
         // crystal off when disabled or stopped
         crystalAmpOn <= !ampOffQ && stateD != PS_STOP;
         coreClkEn    <= stateD == PS_RUN || stateD == PS_RING;
         periphClkEn  <= stateD != PS_STOP;
         // reference in stop follows keep bit
         bandgapOn    <= stateD != PS_STOP || refKeepQ;
      end
   end

   // ------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ------------------------------------------------------------
   // Read mux; data stands one cycle, then returns to zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= ZERO8;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_POWER_CONTROL: rdata <= {6'h00, stateQ == PS_STOP,
                                          stateQ == PS_IDLE};
            ADDR_EXT_FLAGS: rdata <= {4'h0, srcSelQ, ringActQ,
                                      ringWakeQ, refKeepQ};
            ADDR_POWER_MANAGE: rdata <= {divQ, autoRstQ, 1'b0,
                                         ampOffQ, 3'h0};
            ADDR_ACTIVITY: rdata <= {statS.pfLevel, statS.hiLevel,
                                     statS.loLevel, xtReadyQ,
                                     statS.p1Tx, statS.p1Rx,
                                     statS.p0Tx, statS.p0Rx};
            default: rdata <= ZERO8;
         endcase
      end else begin
         rdata <= ZERO8;
      end
   end
endmodule

// [hw/pmm_pkg.sv]
// Constants, types and register layout of the power mode clock control
//
// Behaviour
// - Source select 1 runs from crystal, 0 from ring oscillator.
// - Select 0 to 1 accepted only with crystal ready and amp enabled.
// - Ring active flag reads 1 while ring clocks the CPU; resets 0.
// - Divider 01 is 4 clocks, 10 is 64, 11 is 1024; 10/11 only from 01.
// - Auto restore enable brings divider back to 4 clocks on events.
// - Amp disable stops crystal; set only while source select is 0.
// - Three read-only flags show power-fail, high, low level in service.
// - Crystal ready flag reads 1 once crystal is stable; resets 1.
// - Four read-only flags show tx and rx activity for both ports.
// - Power control bit 0 enters Idle; core clock stops, peripherals keep running.
// - Idle ends on any interrupt or reset.
// - Power control bit 1 enters Stop; all clocks and crystal off.
// - Stop ends on external, real-time clock interrupt or reset; supply events too with band-gap kept.
// - Reference keep bit holds band-gap on during Stop; resets 0.
// - With band-gap kept, supply warning and power-fail reset wake Stop.
// - Ring wake select makes CPU run from ring right after Stop.
// - After ring wake, switch to crystal after 65,536 crystal clocks.
// - Ring active flag held 1 during ring period, cleared on hand-back.
// - New divider rate takes effect one instruction cycle later.
// - Restore on serviceable external irq, start bit with rx, tx write.
// - Crystal ready sets 65,536 clocks after startup once amp enabled.
// - Automatic restore changes only the divider, not the source.
package pmm_pkg;

   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
   localparam logic [7:0] ADDR_EXT_FLAGS     = 8'h91;
   localparam logic [7:0] ADDR_POWER_MANAGE  = 8'hC4;
   localparam logic [7:0] ADDR_ACTIVITY      = 8'hC5;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int PC_IDLE_BIT    = 0;
   localparam int PC_STOP_BIT    = 1;
   localparam int EX_REFKEEP_BIT = 0;
   localparam int EX_RINGWAKE_BIT= 1;
   localparam int EX_RINGACT_BIT = 2;
   localparam int EX_SRCSEL_BIT  = 3;
   localparam int PM_AMPOFF_BIT  = 3;
   localparam int PM_AUTORST_BIT = 5;
   localparam int PM_DIV_LO      = 6;
   localparam int PM_DIV_HI      = 7;
   localparam int ST_XTREADY_BIT = 4;

   // -------------------------------------------------------------
   // Divider codes and reset values
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      DIV_RSVD = 2'h0,
      DIV_4    = 2'h1,
      DIV_64   = 2'h2,
      DIV_1024 = 2'h3
   } divCode_t;

   localparam logic [10:0] CYC_4    = 11'h004;
   localparam logic [10:0] CYC_64   = 11'h040;
   localparam logic [10:0] CYC_1024 = 11'h400;

   localparam logic RST_SRCSEL   = 1'b1;
   localparam logic RST_XTREADY  = 1'b1;
   localparam logic [7:0] ZERO8  = 8'h00;

   // Crystal warm-up / hand-back interval in crystal clocks
   localparam int WARMUP_CLKS = 65536;

   // Power states, Gray coded along run-idle-stop-ringwake
   typedef enum logic [1:0] {
      PS_RUN  = 2'b00,
      PS_IDLE = 2'b01,
      PS_STOP = 2'b11,
      PS_RING = 2'b10
   } pwrState_t;

   // -------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } regReq_t;

   typedef struct packed {
      logic pfLevel;     // power-fail level in service
      logic hiLevel;
      logic loLevel;
      logic p1Tx;
      logic p1Rx;
      logic p0Tx;
      logic p0Rx;
   } coreStat_t;

   typedef struct packed {
      logic extIrq;       // serviceable external interrupt
      logic rtcIrq;
      logic supplyWarn;   // early supply warning interrupt
      logic pfReset;      // power-fail reset request
      logic anyIrq;
      logic startBit;     // start bit seen with receiver enabled
      logic txWrite;      // write to a transmit buffer
   } wakeEv_t;

endpackage

// [hw/pmm_sync.sv]
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pmm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1Q;
   logic [W-1:0] s2Q;
   logic [W-1:0] s3Q;

   // Capture chain; first stage feeds only the second
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1Q <= '0;
         s2Q <= '0;
         s3Q <= '0;
      end else begin
         s1Q <= din;
         s2Q <= s1Q;
         s3Q <= s2Q;
      end
   end

   // Output follows once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2Q[i] == s3Q[i]) begin
               dout[i] <= s3Q[i];
            end
         end
      end
   end
endmodule

// [hw/pmm_count.sv]
// Interval counter that reports completion after a set number of clocks
`timescale 1ns/10ps
module pmm_count #(
   parameter int LIMIT = 65536
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic run,
   output logic      done
);
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

   logic [CW-1:0] cntQ;

   // Counts while run is held; clears when run drops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cntQ <= '0;
         done <= 1'b0;
      end else if (!run) begin
         cntQ <= '0;
         done <= 1'b0;
      end else if (!done) begin
         if (cntQ == LAST) begin
            done <= 1'b1;
         end else begin
            cntQ <= cntQ + 1'b1;
         end
      end
   end
endmodule

// [verif/pmm_core_model.sv]
// Behavioural core side: interrupt events and status levels
`timescale 1ns/10ps
module pmm_core_model (
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire pmm_pkg::wakeEv_t   evIn,
   input  wire logic               evGo,
   input  wire pmm_pkg::coreStat_t stIn,
   output pmm_pkg::wakeEv_t        wakeEv,
   output pmm_pkg::coreStat_t      coreStat
);
   import pmm_pkg::*;
   logic [2:0] holdQ;
   // Events stand six cycles, past the input filter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         holdQ  <= 3'h0;
         wakeEv <= '0;
      end else if (evGo) begin
         holdQ  <= 3'h6;
         wakeEv <= evIn;
      end else if (holdQ != 3'h0) begin
         holdQ <= holdQ - 3'h1;
         if (holdQ == 3'h1) wakeEv <= '0;
      end
   end
   // Levels as the core reports them
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) coreStat <= '0;
      else coreStat <= stIn;
   end
endmodule

// [verif/power_mode_clock_control_properties.sv]
// Port-level checks of the power mode clock control
`timescale 1ns/10ps
module power_mode_clock_control_properties (
   input wire logic             clk,
   input wire logic             arst_n,
   input wire pmm_pkg::wakeEv_t wakeEv,
   input wire logic             cpuFromRing,
   input wire logic             crystalAmpOn,
   input wire logic             coreClkEn,
   input wire logic             periphClkEn,
   input wire logic             bandgapOn,
   input wire logic             cycleStrobe,
   input wire logic [1:0]       activeDiv
);
   import pmm_pkg::*;
   logic wakeOk;
   logic pwrWake;
   // Causes that may end Stop
   assign wakeOk  = wakeEv.extIrq | wakeEv.rtcIrq;
   assign pwrWake = bandgapOn & (wakeEv.supplyWarn | wakeEv.pfReset);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ----------------------
   // Power states and rates
   // ----------------------
   sequence sUp; ##[1:8] periphClkEn; endsequence
   sequence sQuiet; !(wakeOk | pwrWake) [*8]; endsequence
   a_stop_clocks_off: assert property (
      !periphClkEn && !$past(periphClkEn) |-> !coreClkEn && !crystalAmpOn)
      else $error("clock or crystal on in stop");
   a_bandgap_run: assert property (
      periphClkEn && $past(periphClkEn) |-> bandgapOn)
      else $error("band-gap off outside stop");
   a_stop_wake_ext: assert property (
      $rose(wakeOk) && !periphClkEn |-> sUp)
      else $error("no exit from stop on interrupt");
   a_supply_wake: assert property (
      $rose(pwrWake) && !periphClkEn |-> sUp)
      else $error("no exit from stop on supply event");
   a_stop_hold: assert property (
      sQuiet ##0 !periphClkEn |=> !periphClkEn)
      else $error("stop left without cause");
   a_idle_wake: assert property (
      $rose(wakeEv.anyIrq) && !coreClkEn && periphClkEn
      |-> ##[1:8] coreClkEn)
      else $error("no exit from idle on interrupt");
   a_div_legal: assert property (activeDiv != DIV_RSVD)
      else $error("reserved divider code in use");
   a_div_no_jump: assert property (
      activeDiv != $past(activeDiv) && $past(activeDiv) != DIV_4
      |-> activeDiv == DIV_4)
      else $error("divider skipped the 4 clock rate");
   a_strobe_gap: assert property (
      cycleStrobe |=> !cycleStrobe [*3])
      else $error("instruction cycle under 4 clocks");
   a_amp_off_ring: assert property (
      !crystalAmpOn && periphClkEn && $past(periphClkEn) |-> cpuFromRing)
      else $error("crystal off while crystal clocks");
endmodule
bind power_mode_clock_control power_mode_clock_control_properties i_props (
   .clk(clk), .arst_n(arst_n), .wakeEv(wakeEv),
   .cpuFromRing(cpuFromRing), .crystalAmpOn(crystalAmpOn),
   .coreClkEn(coreClkEn), .periphClkEn(periphClkEn),
   .bandgapOn(bandgapOn), .cycleStrobe(cycleStrobe),
   .activeDiv(activeDiv));

// [verif/power_mode_clock_control_bench.sv]
// Self-checking bench of the power mode clock control
`timescale 1ns/10ps
module power_mode_clock_control_bench;
   import pmm_pkg::*;
   localparam int WU = 16;
   localparam logic [7:0] DW [7] = '{8'h80, 8'hC0, 8'h40, 8'hC0,
                                     8'h00, 8'h80, 8'h40};
   localparam logic [7:0] DE [7] = '{8'h80, 8'h80, 8'h40, 8'hC0,
                                     8'hC0, 8'hC0, 8'h40};
   localparam logic [6:0] RE [3] = '{7'h40, 7'h02, 7'h01};
   localparam logic [7:0] SX [4] = '{8'h08, 8'h08, 8'h09, 8'h09};
   localparam logic [6:0] NW [4] = '{7'h1F, 7'h1F, 7'h07, 7'h07};
   localparam logic [6:0] WK [4] = '{7'h20, 7'h40, 7'h10, 7'h08};
   logic        clk;
   logic        arst_n;
   logic        evGo;
   logic        xtalOscOk;
   logic [1:0]  wantDiv;
   logic [31:0] seed;
   regReq_t     req;
   wakeEv_t     evIn;
   wakeEv_t     wakeEv;
   coreStat_t   stIn;
   coreStat_t   coreStat;
   logic [7:0]  rdata;
   logic        cpuFromRing, crystalAmpOn, coreClkEn;
   logic        periphClkEn, bandgapOn, cycleStrobe;
   logic [1:0]  activeDiv;
   int          badCount;
   int          nTests;

   power_mode_clock_control #(.WARMUP(WU)) i_power_mode_clock_control (
      .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata),
      .coreStat(coreStat), .wakeEv(wakeEv), .xtalOscOk(xtalOscOk),
      .cpuFromRing(cpuFromRing), .crystalAmpOn(crystalAmpOn),
      .coreClkEn(coreClkEn), .periphClkEn(periphClkEn),
      .bandgapOn(bandgapOn), .cycleStrobe(cycleStrobe),
      .activeDiv(activeDiv));
   pmm_core_model i_pmm_core_model (
      .clk(clk), .arst_n(arst_n), .evIn(evIn), .evGo(evGo),
      .stIn(stIn), .wakeEv(wakeEv), .coreStat(coreStat));

   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Crystal oscillates one cycle after its amplifier turns on
   always @(posedge clk) xtalOscOk <= crystalAmpOn;

   // ---------------------
   // Helpers and sequence
   // ---------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic int perOf(input logic [1:0] c);
      return (c == DIV_64) ? 64 : (c == DIV_1024) ? 1024 : 4;
   endfunction
   function automatic logic pick(input int s);
      case (s)
         0: return coreClkEn;
         1: return periphClkEn;
         2: return cpuFromRing;
         3: return cycleStrobe;
         default: return activeDiv === wantDiv;
      endcase
   endfunction
   task automatic finishTest();
      if (badCount == 0 && nTests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      nTests++;
      if (e !== g) begin
         badCount++;
         $display("unexpected %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic waitOn(input int s, input logic v, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         @(posedge clk);
         #2;
         if (pick(s) === v) break;
      end
      if (i == lim) begin
         badCount++;
         $display("unexpected wait %0d expected %0h seen none", s, v);
         finishTest();
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, e);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      req <= '0;
      #2;
      chk($sformatf("reg %h", a), e, rdata);
      @(posedge clk);
   endtask
   task automatic fire(input wakeEv_t e);
      evIn <= e;
      evGo <= 1'b1;
      @(posedge clk);
      evGo <= 1'b0;
      @(posedge clk);
   endtask
   task automatic period(input logic [1:0] c);
      int n;
      wantDiv = c;
      waitOn(4, 1'b1, 2100);
      waitOn(3, 1'b1, 2100);
      for (n = 1; n < 2100; n++) begin
         @(posedge clk);
         #2;
         if (cycleStrobe === 1'b1) break;
      end
      chk("cycle period", perOf(c), n);
   endtask

   // Main sequence: reset, registers, divider, sources, power states
   initial begin
      req = '0;
      evIn = '0;
      evGo = 1'b0;
      stIn = '0;
      wantDiv = DIV_4;
      badCount = 0;
      nTests = 0;
      seed = 32'h1026E300;
      arst_n = 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(ADDR_POWER_CONTROL, 8'h00);
      rd(ADDR_EXT_FLAGS, 8'h08);
      rd(ADDR_POWER_MANAGE, 8'h40);
      rd(ADDR_ACTIVITY, 8'h10);
      rd(8'h00, 8'h00);
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         stIn <= seed[6:0];
         tick(6);
         rd(ADDR_ACTIVITY, {seed[6:4], 1'b1, seed[3:0]});
      end
      stIn <= '0;
      for (int k = 0; k < 7; k++) begin
         wr(ADDR_POWER_MANAGE, DW[k]);
         rd(ADDR_POWER_MANAGE, DE[k]);
         period(DE[k][7:6]);
      end
      wr(ADDR_EXT_FLAGS, 8'h00);
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_POWER_MANAGE, 8'h80);
         fire(RE[k]);
         tick(8);
         rd(ADDR_POWER_MANAGE, 8'h80);
         wr(ADDR_POWER_MANAGE, 8'hA0);
         fire(RE[k]);
         tick(8);
         rd(ADDR_POWER_MANAGE, 8'h60);
         rd(ADDR_EXT_FLAGS, 8'h04);
      end
      waitOn(2, 1'b1, 2100);
      wr(ADDR_POWER_MANAGE, 8'h48);
      rd(ADDR_POWER_MANAGE, 8'h48);
      chk("crystal amp", 1'b0, crystalAmpOn);
      rd(ADDR_ACTIVITY, 8'h00);
      wr(ADDR_EXT_FLAGS, 8'h08);
      rd(ADDR_EXT_FLAGS, 8'h04);
      wr(ADDR_POWER_MANAGE, 8'h40);
      wr(ADDR_EXT_FLAGS, 8'h08);
      rd(ADDR_EXT_FLAGS, 8'h04);
      tick(WU + 20);
      rd(ADDR_ACTIVITY, 8'h10);
      wr(ADDR_EXT_FLAGS, 8'h08);
      rd(ADDR_EXT_FLAGS, 8'h08);
      waitOn(2, 1'b0, 2100);
      wr(ADDR_POWER_MANAGE, 8'h48);
      rd(ADDR_POWER_MANAGE, 8'h40);
      wr(ADDR_POWER_CONTROL, 8'h01);
      tick(2);
      chk("core clock", 1'b0, coreClkEn);
      chk("periph clock", 1'b1, periphClkEn);
      fire(7'h04);
      waitOn(0, 1'b1, 12);
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_EXT_FLAGS, SX[k]);
         wr(ADDR_POWER_CONTROL, 8'h02);
         tick(2);
         chk("periph clock", 1'b0, periphClkEn);
         chk("crystal amp", 1'b0, crystalAmpOn);
         chk("band-gap", SX[k][0], bandgapOn);
         fire(NW[k]);
         tick(10);
         chk("periph clock", 1'b0, periphClkEn);
         fire(WK[k]);
         waitOn(1, 1'b1, 12);
         tick(WU + 30);
         chk("band-gap", 1'b1, bandgapOn);
      end
      wr(ADDR_EXT_FLAGS, 8'h0A);
      wr(ADDR_POWER_CONTROL, 8'h02);
      tick(2);
      fire(7'h40);
      waitOn(1, 1'b1, 12);
      chk("ring clock", 1'b1, cpuFromRing);
      rd(ADDR_EXT_FLAGS, 8'h0E);
      chk("ring clock", 1'b1, cpuFromRing);
      waitOn(2, 1'b0, WU + 20);
      rd(ADDR_EXT_FLAGS, 8'h0A);
      finishTest();
   end
endmodule
